// File: rtl/ahs_regs.vh
// ahs_regs.vh: register offsets, field positions, reset values, method codes
// assumes: included by the homing sequencer modules; definitions only
`ifndef AHS_REGS_VH
`define AHS_REGS_VH
// register offsets (word addresses on the plain port)
`define AHS_REG_CTRL      4'h0
`define AHS_REG_METHOD    4'h1
`define AHS_REG_OFFSET    4'h2
`define AHS_REG_TRAVEL    4'h3
`define AHS_REG_STATUS    4'h4
`define AHS_REG_POSITION  4'h5
`define AHS_REG_ZEROPOS   4'h6
// control bits (write one to act; pulses)
`define AHS_CTRL_START    0
`define AHS_CTRL_ABORT    1
`define AHS_CTRL_PWRON    2
// status bits
`define AHS_ST_BUSY       0
`define AHS_ST_DONE       1
`define AHS_ST_OVERRUN    2
`define AHS_ST_UNDEF      3
`define AHS_ST_DIR        4
`define AHS_ST_MOVE       5
// reset values
`define AHS_RST_METHOD    8'h00
`define AHS_RST_OFFSET    32'h00000000
`define AHS_RST_TRAVEL    32'h00010000
// method codes, signed 8 bit
`define AHS_M_INC_NEG     8'hfa
`define AHS_M_INC_POS     8'hf9
`define AHS_M_ABS         8'hfb
`define AHS_M_NOHOME      8'hfe
`define AHS_M_RESET       8'hff
`define AHS_M_BLK_NEG     8'hf8
`define AHS_M_BLK_POS     8'hf7
`endif

// File: rtl/ahs_sync3.v
// ahs_sync3.v: three flip-flop synchroniser with agreement filter
// assumes: asynchronous pin input, one clock domain mclk
`timescale 1ns/1ps
module ahs_sync3 (
  mclk,
  rst,
  pinIn,
  levelOut
);
  input  wire mclk;
  input  wire rst;
  input  wire pinIn;
  output reg  levelOut;

  reg s1Q;
  reg s2Q;
  reg s3Q;

  // first stage read only by the second; level moves when stages 2,3 agree
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1Q      <= 1'b0;
      s2Q      <= 1'b0;
      s3Q      <= 1'b0;
      levelOut <= 1'b0;
    end else begin
      s1Q <= pinIn;
      s2Q <= s1Q;
      s3Q <= s2Q;
      if (s2Q == s3Q) begin
        levelOut <= s3Q;
      end
    end
  end
endmodule // ahs_sync3

// File: rtl/ahs_edge_unit.v
// ahs_edge_unit.v: per-input synchroniser plus rise and fall pulses
// assumes: inputs are pins outside the mclk domain
`timescale 1ns/1ps
module ahs_edge_unit #(
  parameter N = 4
) (
  mclk,
  rst,
  pins,
  level,
  rise,
  fall
);
  input  wire         mclk;
  input  wire         rst;
  input  wire [N-1:0] pins;
  output wire [N-1:0] level;
  output wire [N-1:0] rise;
  output wire [N-1:0] fall;

  reg [N-1:0] prevQ;
  genvar i;

  // one filtered synchroniser per input
  generate
    for (i = 0; i < N; i = i + 1) begin : gSync
      ahs_sync3 uSync (
        .mclk     (mclk),
        .rst      (rst),
        .pinIn    (pins[i]),
        .levelOut (level[i])
      );
    end
  endgenerate

  // edge detection on the filtered levels
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prevQ <= {N{1'b0}};
    end else begin
      prevQ <= level;
    end
  end
  assign rise = level & ~prevQ;
  assign fall = ~level & prevQ;
endmodule // ahs_edge_unit

// File: rtl/ahs_homing_sequencer.v
// ahs_homing_sequencer.v: homing sequencer for one servo axis
// assumes: motion profile follows moveEn/moveDir/backOff, position comes in
// as an absolute count on mclk, pins are asynchronous
//
// Contract
// R1: block homing positive: after block, back off half travel, then zero.
// R2: method -6 moves negative, -7 moves positive, incremental encoders.
// R3: method -5 references at power-up: absolute position plus offset.
// R4: repeating -5 with same offset gives same result; zero offset is raw.
// R5: methods -4, -3, 15, 16 are undefined and do nothing.
// R6: method -2: no motion, add offset, done at first power stage on.
// R7: method -1: actual position becomes zero, then offset added.
// R8: method 1: go negative, reverse on limit, zero pulse after limit fall.
// R9: method 2: go positive, reverse on limit, zero pulse after limit fall.
// R10: method 3: go positive, reverse on mark rise, pulse after mark fall.
// R11: method 4: go negative, reverse on mark rise, pulse after mark fall.
// R12: method 5: positive, or negative if mark inactive; pulse after fall.
// R13: method 6: go negative, reverse on mark fall, pulse after mark rise.
// R14: method 7: go positive, reverse on mark active, pulse after fall.
// R15: method 8: mark active takes first pulse, else reverse, after rise.
// R16: method 9: reverse when mark inactive, pulse after rise; active: first.
// R17: method 10: pass the mark, first pulse after its falling edge.
// R18: method 11: negative switch, reverse on mark, pulse after fall.
// R19: method 12: mark active takes first pulse, else reverse, after rise.
// R20: method 13: reverse past mark, pulse after rise; active: first pulse.
// R21: method 14: reverse on mark active, first pulse after falling edge.
// R22: methods 17 to 30 move as 1 to 14, zero taken at the edge.
// R23: leaving the travel range stops the axis and flags overrun.
// R24: done flag set when zero latched, cleared at each new run.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "ahs_regs.vh"
module ahs_homing_sequencer (
  mclk,
  rst,
  regAddr,
  regWdata,
  regWr,
  regRd,
  regRdata,
  limitNegPin,
  limitPosPin,
  refMarkPin,
  zeroPulsePin,
  blockHit,
  backOffDone,
  encAbsPos,
  actualPos,
  moveEn,
  moveDir,
  backOff,
  backOffDist,
  homeValid,
  homePos,
  homeDone,
  overrun
);
  input  wire        mclk;
  input  wire        rst;
  input  wire [3:0]  regAddr;
  input  wire [31:0] regWdata;
  input  wire        regWr;
  input  wire        regRd;
  output reg  [31:0] regRdata;
  input  wire        limitNegPin;
  input  wire        limitPosPin;
  input  wire        refMarkPin;
  input  wire        zeroPulsePin;
  input  wire        blockHit;
  input  wire        backOffDone;
  input  wire [31:0] encAbsPos;
  input  wire [31:0] actualPos;
  output reg         moveEn;
  output reg         moveDir;
  output reg         backOff;
  output reg  [31:0] backOffDist;
  output reg         homeValid;
  output reg  [31:0] homePos;
  output reg         homeDone;
  output reg         overrun;

  localparam S_IDLE   = 3'd0;
  localparam S_SEEK   = 3'd1;
  localparam S_ARM    = 3'd2;
  localparam S_WAITZ  = 3'd3;
  localparam S_BACK   = 3'd4;
  localparam S_LATCH  = 3'd5;

  // synchronised pins: 0 limitNeg, 1 limitPos, 2 mark, 3 zero pulse
  wire [3:0] lvl;
  wire [3:0] rise;
  wire [3:0] fall;

  ahs_edge_unit #(
    .N (4)
  ) uEdge (
    .mclk  (mclk),
    .rst   (rst),
    .pins  ({zeroPulsePin, refMarkPin, limitPosPin, limitNegPin}),
    .level (lvl),
    .rise  (rise),
    .fall  (fall)
  );

  reg [7:0]  methodQ;
  reg [31:0] offsetQ;
  reg [31:0] travelQ;
  reg [2:0]  stateQ;
  reg        undefQ;
  reg        pwrSeenQ;
  reg        useZeroQ;
  reg        armRiseQ;  // arming edge of the signal is a rise
  reg        sigMarkQ;  // watched signal is the mark, else the limit
  reg [31:0] startPosQ;
  reg [31:0] latchPosQ;

  wire        wrCtrl  = regWr && (regAddr == `AHS_REG_CTRL);
  wire        startCmd = wrCtrl && regWdata[`AHS_CTRL_START];
  wire        abortCmd = wrCtrl && regWdata[`AHS_CTRL_ABORT];
  wire        pwrCmd   = wrCtrl && regWdata[`AHS_CTRL_PWRON];
  wire signed [7:0] mS = $signed(methodQ);
  // standard methods folded onto 1..14, zero pulse unused for 17..30
  wire [7:0]  baseM   = (mS >= 8'sd17) ? methodQ - 8'd16 : methodQ;
  wire        noZero  = (mS >= 8'sd17) && (mS <= 8'sd30);  // [R22]
  wire        stdM    = (mS >= 8'sd1) && (mS <= 8'sd14) || noZero;
  wire        isUndef = (mS == -8'sd4) || (mS == -8'sd3) ||
                        (mS == 8'sd15) || (mS == 8'sd16);   // [R5]
  wire        limNeg  = lvl[0];
  wire        limPos  = lvl[1];
  wire        mark    = lvl[2];
  wire        zeroP   = rise[3];
  // the watched limit is fixed by the method, not by the present direction,
  // so the switch that reversed the axis is still the one watched afterwards
  wire        limSel  = (baseM == 8'd2);                   // [R8] [R9]
  wire        watchRi = sigMarkQ ? rise[2] : (limSel ? rise[1] : rise[0]);
  wire        watchFa = sigMarkQ ? fall[2] : (limSel ? fall[1] : fall[0]);
  wire [31:0] travelD = actualPos - startPosQ;
  wire [31:0] travAbs = travelD[31] ? (~travelD + 32'h1) : travelD;

  // start direction per method: 1 is positive
  function startDir;
    input [7:0] m;
    input       mk;
    begin
      case (m)
        8'd1, 8'd4, 8'd6, 8'd11, 8'd12, 8'd13, 8'd14: startDir = 1'b0;
        8'd5: startDir = mk;                                  // [R12]
        default: startDir = 1'b1;
      endcase
    end
  endfunction

  // register writes
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      methodQ <= `AHS_RST_METHOD;
      offsetQ <= `AHS_RST_OFFSET;
      travelQ <= `AHS_RST_TRAVEL;
    end else if (regWr) begin
      case (regAddr)
        `AHS_REG_METHOD: methodQ <= regWdata[7:0];
        `AHS_REG_OFFSET: offsetQ <= regWdata;
        `AHS_REG_TRAVEL: travelQ <= regWdata;
        default: ;
      endcase
    end
  end

  // register reads, data one cycle after the strobe
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdata <= 32'h0;
    end else if (regRd) begin
      case (regAddr)
        `AHS_REG_METHOD:   regRdata <= {24'h0, methodQ};
        `AHS_REG_OFFSET:   regRdata <= offsetQ;
        `AHS_REG_TRAVEL:   regRdata <= travelQ;
        `AHS_REG_STATUS:   regRdata <= {26'h0, moveEn, moveDir, undefQ,
                                        overrun, homeDone,
                                        (stateQ != S_IDLE)};
        `AHS_REG_POSITION: regRdata <= actualPos;
        `AHS_REG_ZEROPOS:  regRdata <= homePos;
        default:           regRdata <= 32'h0;
      endcase
    end else begin
      regRdata <= 32'h0;
    end
  end

  // homing state machine
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      stateQ      <= S_IDLE;
      moveEn      <= 1'b0;
      moveDir     <= 1'b0;
      backOff     <= 1'b0;
      backOffDist <= 32'h0;
      homeValid   <= 1'b0;
      homePos     <= 32'h0;
      homeDone    <= 1'b0;
      overrun     <= 1'b0;
      undefQ      <= 1'b0;
      pwrSeenQ    <= 1'b0;
      useZeroQ    <= 1'b0;
      armRiseQ    <= 1'b0;
      sigMarkQ    <= 1'b0;
      startPosQ   <= 32'h0;
      latchPosQ   <= 32'h0;
    end else begin
      homeValid <= 1'b0;
      backOff   <= 1'b0;
      if (pwrCmd) begin
        pwrSeenQ <= 1'b1;
      end
      if (abortCmd) begin
        stateQ <= S_IDLE;
        moveEn <= 1'b0;
      end else begin
        case (stateQ)
          S_IDLE: begin
            // first power stage on: -5 references, -2 reports done
            if (pwrCmd && !pwrSeenQ && mS == -8'sd5) begin
              homePos   <= encAbsPos + offsetQ;              // [R3] [R4]
              homeValid <= 1'b1;
              homeDone  <= 1'b1;
            end else if (pwrCmd && !pwrSeenQ && mS == -8'sd2) begin
              homePos   <= actualPos + offsetQ;              // [R6]
              homeValid <= 1'b1;
              homeDone  <= 1'b1;
            end else if (startCmd) begin
              homeDone  <= 1'b0;                             // [R24]
              overrun   <= 1'b0;
              undefQ    <= 1'b0;
              startPosQ <= actualPos;
              useZeroQ  <= !noZero;
              // dispatch on the method code
              if (isUndef) begin
                undefQ <= 1'b1;                              // [R5]
              end else if (mS == -8'sd5) begin
                latchPosQ <= encAbsPos;                      // [R3] [R4]
                stateQ    <= S_LATCH;
              end else if (mS == -8'sd2) begin
                latchPosQ <= actualPos;                      // [R6]
                stateQ    <= S_LATCH;
              end else if (mS == -8'sd1) begin
                latchPosQ <= 32'h0;                          // [R7]
                stateQ    <= S_LATCH;
              end else if (mS == -8'sd6 || mS == -8'sd7 ||
                           mS == -8'sd8 || mS == -8'sd9) begin
                moveDir <= (mS == -8'sd7) || (mS == -8'sd9); // [R2]
                moveEn  <= 1'b1;
                stateQ  <= (mS <= -8'sd8) ? S_SEEK : S_WAITZ;
              end else if (stdM) begin
                // methods 8, 9, 12, 13 with mark present at start: zero on first pulse
                sigMarkQ <= !(baseM == 8'd1 || baseM == 8'd2);
                moveDir  <= startDir(baseM, mark);
                moveEn   <= 1'b1;
                if ((baseM == 8'd8 || baseM == 8'd9 || baseM == 8'd12 ||
                     baseM == 8'd13) && mark) begin
                  if (noZero) begin
                    // no zero pulse in use: the active mark is the zero
                    latchPosQ <= actualPos;                      // [R22]
                    moveEn    <= 1'b0;
                    stateQ    <= S_LATCH;
                  end else begin
                    stateQ <= S_WAITZ; // [R15] [R16] [R19] [R20]
                  end
                end else begin
                  // 6,8,9,12,13 arm on mark rise; the rest on fall
                  armRiseQ <= (baseM == 8'd6 || baseM == 8'd8 ||
                               baseM == 8'd9 || baseM == 8'd12 ||
                               baseM == 8'd13);                // [R13]
                  stateQ   <= S_SEEK;
                end
              end else begin
                undefQ <= 1'b1;
              end
            end
          end
          S_SEEK: begin
            // block methods wait for the block, others for the reversal edge
            if (mS == -8'sd8 || mS == -8'sd9) begin
              if (blockHit) begin
                moveEn      <= 1'b0;
                backOff     <= 1'b1;
                backOffDist <= {1'b0, travelQ[31:1]};        // [R1]
                stateQ      <= S_BACK;
              end
            end else if (armRiseQ ? watchFa : watchRi) begin
              // reversal edge reached
              moveDir <= ~moveDir;            // [R8] [R9] [R10] [R11] [R14]
              if (baseM == 8'd10) begin
                moveDir <= moveDir;                          // [R17]
              end
              stateQ  <= S_ARM;
            end
          end
          S_ARM: begin
            // arming edge: latch now, or wait for the zero pulse
            if (armRiseQ ? watchRi : watchFa) begin
              if (!useZeroQ) begin
                latchPosQ <= actualPos;                      // [R22]
                moveEn    <= 1'b0;
                stateQ    <= S_LATCH;
              end else begin
                stateQ <= S_WAITZ;              // [R18] [R21]
              end
            end
          end
          S_WAITZ: begin
            // first zero pulse sets the zero point
            if (zeroP) begin
              latchPosQ <= actualPos;
              moveEn    <= 1'b0;
              stateQ    <= S_LATCH;
            end
          end
          S_BACK: begin
            // skip the pulse cycle: a done level left from before is stale
            if (backOffDone && !backOff) begin
              latchPosQ <= actualPos;                        // [R1]
              stateQ    <= S_LATCH;
            end
          end
          S_LATCH: begin
            // apply the offset and report the new zero
            homePos   <= latchPosQ + offsetQ;          // [R1] [R7]
            homeValid <= 1'b1;
            homeDone  <= 1'b1;                               // [R24]
            stateQ    <= S_IDLE;
          end
          default: stateQ <= S_IDLE;
        endcase
        // range supervision while moving
        if (moveEn && (stateQ != S_IDLE) && (travAbs > travelQ)) begin
          moveEn  <= 1'b0;                                   // [R23]
          overrun <= 1'b1;
          stateQ  <= S_IDLE;
        end
      end
    end
  end
endmodule // ahs_homing_sequencer

// File: tb/ahs_axis_model.sv
// ahs_axis_model.sv: behavioural axis with encoder, switches, cam and block
// assumes: one count per 16 mclk while moveEn is high, start position 3
`timescale 1ns/1ps
module ahs_axis_model #(
  parameter ENC_BIAS = 1000
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        moveEn,
  input  wire        moveDir,
  input  wire        backOff,
  input  wire [31:0] backOffDist,
  output wire        limitNegPin,
  output wire        limitPosPin,
  output wire        refMarkPin,
  output wire        zeroPulsePin,
  output wire        blockHit,
  output wire        backOffDone,
  output wire [31:0] encAbsPos,
  output wire [31:0] actualPos
);
  reg signed [31:0] posQ;
  reg        [3:0]  divQ;
  reg        [2:0]  boQ;
  // slow steps keep each pin level far longer than the input filter
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      posQ <= 32'sh3;
      divQ <= 4'h0;
      boQ  <= 3'h0;
    end else begin
      divQ <= divQ + 4'h1;
      if (backOff)
        posQ <= posQ - $signed(backOffDist);
      else if (moveEn && divQ == 4'hf)
        posQ <= moveDir ? posQ + 32'sh1 : posQ - 32'sh1;
      if (backOff)
        boQ <= 3'h5;
      else if (boQ > 3'h1)
        boQ <= boQ - 3'h1;
    end
  end
  // switch, cam and pulse levels follow the position
  assign limitPosPin  = posQ >= 200;
  assign limitNegPin  = posQ <= -200;
  assign refMarkPin   = posQ >= 64 && posQ < 100;
  assign zeroPulsePin = posQ[4:0] == 5'h0;
  assign blockHit     = posQ >= 300;
  assign backOffDone  = boQ == 3'h1; // level until the next back-off
  assign actualPos    = posQ;
  assign encAbsPos    = posQ + ENC_BIAS;
endmodule // ahs_axis_model

// File: tb/ahs_hs_chk.sv
// ahs_hs_chk.sv: concurrent checks on the homing sequencer ports
// assumes: bound into ahs_homing_sequencer, single clock mclk
`timescale 1ns/1ps
`include "ahs_regs.vh"
module ahs_hs_chk (
  input wire        mclk,
  input wire        rst,
  input wire [3:0]  regAddr,
  input wire [31:0] regWdata,
  input wire        regWr,
  input wire        moveEn,
  input wire        moveDir,
  input wire        backOff,
  input wire [31:0] backOffDist,
  input wire        homeValid,
  input wire [31:0] homePos,
  input wire        homeDone,
  input wire        overrun
);
  reg  [7:0]  metQ;
  reg  [31:0] offQ;
  reg  [31:0] travQ;
  wire        start;
  assign start = regWr && regAddr == `AHS_REG_CTRL && regWdata[0];
  // shadows of method, offset and travel
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      metQ  <= `AHS_RST_METHOD;
      offQ  <= `AHS_RST_OFFSET;
      travQ <= `AHS_RST_TRAVEL;
    end else if (regWr) begin
      if (regAddr == `AHS_REG_METHOD)
        metQ <= regWdata[7:0];
      if (regAddr == `AHS_REG_OFFSET)
        offQ <= regWdata;
      if (regAddr == `AHS_REG_TRAVEL)
        travQ <= regWdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // checks on outputs against their causes
  back_dist_a: assert property (backOff |->
    backOffDist == (travQ >> 1))
    else $error("back-off distance not half travel");
  back_pulse_a: assert property (backOff |=> !backOff)
    else $error("back-off longer than one cycle");
  overrun_stop_a: assert property (overrun |-> !moveEn)
    else $error("axis moving with overrun");
  overrun_hold_a: assert property (overrun && !start |=> overrun)
    else $error("overrun dropped before restart");
  valid_done_a: assert property (homeValid |-> homeDone)
    else $error("zero latched without done");
  done_clear_a: assert property (start && homeDone |->
    ##[1:2] !homeDone)
    else $error("done not cleared by new run");
  undef_idle_a: assert property (start && (metQ == 8'hfc
    || metQ == 8'hfd || metQ == 8'h0f || metQ == 8'h10)
    |=> (!moveEn && !homeValid) [*8])
    else $error("undefined method acted");
  reset_zero_a: assert property (start && metQ == 8'hff && !moveEn
    |-> ##[1:3] homeValid && homePos == offQ)
    else $error("position reset result wrong");
  dir_lim_a: assert property (start && !moveEn && (metQ == 8'h01
    || metQ == 8'h02) |-> ##[1:4] moveEn && moveDir == metQ[1])
    else $error("limit method start direction wrong");
  dir_inc_a: assert property (start && !moveEn && (metQ == 8'hfa
    || metQ == 8'hf9) |-> ##[1:4] moveEn && moveDir == metQ[0])
    else $error("incremental method direction wrong");
endmodule // ahs_hs_chk

bind ahs_homing_sequencer ahs_hs_chk u_chk (
  .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .moveEn(moveEn), .moveDir(moveDir), .backOff(backOff),
  .backOffDist(backOffDist), .homeValid(homeValid), .homePos(homePos),
  .homeDone(homeDone), .overrun(overrun)
);

// File: tb/tb.sv
// tb.sv: self-checking bench for the homing sequencer
// assumes: axis model on the far side, registers on the plain port
`timescale 1ns/1ps
`include "ahs_regs.vh"
module tb;
  typedef struct packed {
    logic [7:0]  m;
    logic [2:0]  c;
    logic [31:0] o;
    logic [31:0] e;
  } ahs_row_t;
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg  [3:0]  regAddr = 4'h0;
  reg  [31:0] regWdata = 32'h0;
  reg         regWr = 1'b0;
  reg         regRd = 1'b0;
  wire [31:0] regRdata, encAbsPos, actualPos, backOffDist, homePos;
  wire        limitNegPin, limitPosPin, refMarkPin, zeroPulsePin;
  wire        blockHit, backOffDone, moveEn, moveDir, backOff;
  wire        homeValid, homeDone, overrun;
  integer     errCount = 0;
  integer     samplesChecked = 0;
  integer     cycles = 0;
  integer     i;
  integer     n;
  reg  [7:0]  undef [0:3] = '{8'hfc, 8'hfd, 8'h0f, 8'h10};
  // method, control bits, offset, expected zero position
  ahs_row_t   rows [0:10] = '{
    '{8'hff, 3'h1, 32'h5, 32'h5},
    '{8'hfe, 3'h4, 32'h5, 32'h8},
    '{8'hfb, 3'h1, 32'h7, 32'h3f2},
    '{8'hf9, 3'h1, 32'h5, 32'h25},
    '{8'hfa, 3'h1, 32'h5, 32'h5},
    '{8'h01, 3'h1, 32'h5, 32'hffffff45},
    '{8'h02, 3'h1, 32'h5, 32'hc5},
    '{8'h03, 3'h1, 32'h5, 32'h25},
    '{8'h12, 3'h1, 32'h5, 32'hcc},
    '{8'h13, 3'h1, 32'h5, 32'h44},
    '{8'hf7, 3'h1, 32'h5, 32'hffff8131}};

  ahs_homing_sequencer dut (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .limitNegPin(limitNegPin), .limitPosPin(limitPosPin),
    .refMarkPin(refMarkPin), .zeroPulsePin(zeroPulsePin),
    .blockHit(blockHit), .backOffDone(backOffDone), .encAbsPos(encAbsPos),
    .actualPos(actualPos), .moveEn(moveEn), .moveDir(moveDir),
    .backOff(backOff), .backOffDist(backOffDist), .homeValid(homeValid),
    .homePos(homePos), .homeDone(homeDone), .overrun(overrun));

  ahs_axis_model u_axis (
    .mclk(mclk), .rst(rst), .moveEn(moveEn), .moveDir(moveDir),
    .backOff(backOff), .backOffDist(backOffDist),
    .limitNegPin(limitNegPin), .limitPosPin(limitPosPin),
    .refMarkPin(refMarkPin), .zeroPulsePin(zeroPulsePin),
    .blockHit(blockHit), .backOffDone(backOffDone),
    .encAbsPos(encAbsPos), .actualPos(actualPos));

  // 50 MHz clock
  initial begin
    forever #10 mclk = ~mclk;
  end

  // cycle ceiling against a hung wait
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errCount = errCount + 1;
      test_done();
    end
  end

  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      samplesChecked = samplesChecked + 1;
      if (s !== e) begin
        errCount = errCount + 1;
        $display("Error %s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge mclk);
      regWr    <= 1'b0;
    end
  endtask

  task rd(input [3:0] a, input [31:0] e, input string nm);
    begin
      @(posedge mclk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge mclk);
      regRd   <= 1'b0;
      #1;
      chk(nm, regRdata, e);
    end
  endtask

  task hrst;
    begin
      @(posedge mclk);
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
    end
  endtask

  // bounded wait for done (ov low) or overrun (ov high)
  task waitFor(input bit ov);
    begin
      n = 0;
      @(posedge mclk);
      #1;
      while ((ov ? overrun : homeDone) !== 1'b1 && n < 8000) begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      if (n == 8000)
        chk("wait", 32'h0, 32'h1);
    end
  endtask

  task test_done;
    begin
      $display("checked %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  initial begin
    hrst();
    rd(`AHS_REG_TRAVEL, `AHS_RST_TRAVEL, "travel");
    rd(`AHS_REG_METHOD, 32'h0, "method");
    rd(`AHS_REG_OFFSET, 32'h0, "offset");
    rd(4'hf, 32'h0, "unmapped");
    chk("homeDone", {31'h0, homeDone}, 32'h0);
    $display("reset test done");
    for (i = 0; i < 11; i = i + 1) begin
      hrst();
      wr(`AHS_REG_OFFSET, rows[i].o);
      wr(`AHS_REG_METHOD, {24'h0, rows[i].m});
      wr(`AHS_REG_CTRL, {29'h0, rows[i].c});
      waitFor(1'b0);
      chk("homePos", homePos, rows[i].e);
      rd(`AHS_REG_ZEROPOS, rows[i].e, "zeroPos");
      chk("overrun", {31'h0, overrun}, 32'h0);
      $display("row %0d done", i);
    end
    // absolute method at power-on, then referenced again
    hrst();
    wr(`AHS_REG_METHOD, {24'h0, `AHS_M_ABS});
    wr(`AHS_REG_CTRL, 32'h4);
    waitFor(1'b0);
    chk("absPos", homePos, 32'h3eb);
    wr(`AHS_REG_CTRL, 32'h1);
    repeat (4) @(posedge mclk);
    waitFor(1'b0);
    chk("absAgain", homePos, 32'h3eb);
    $display("repeat test done");
    for (i = 0; i < 4; i = i + 1) begin
      hrst();
      wr(`AHS_REG_METHOD, {24'h0, undef[i]});
      wr(`AHS_REG_CTRL, 32'h1);
      repeat (8) @(posedge mclk);
      rd(`AHS_REG_STATUS, 32'h8, "status");
      chk("moveEn", {31'h0, moveEn}, 32'h0);
    end
    $display("undefined test done");
    hrst();
    wr(`AHS_REG_TRAVEL, 32'h32);
    wr(`AHS_REG_METHOD, 32'h2);
    wr(`AHS_REG_CTRL, 32'h1);
    waitFor(1'b1);
    chk("moveEn", {31'h0, moveEn}, 32'h0);
    chk("homeDone", {31'h0, homeDone}, 32'h0);
    $display("overrun test done");
    // abort stops a run in progress and leaves the sequencer idle
    hrst();
    wr(`AHS_REG_METHOD, {24'h0, `AHS_M_INC_POS});
    wr(`AHS_REG_CTRL, 32'h1);
    #1;
    chk("moving", {31'h0, moveEn}, 32'h1);
    wr(`AHS_REG_CTRL, 32'h2);
    rd(`AHS_REG_STATUS, 32'h10, "aborted");
    $display("abort test done");
    test_done();
  end
endmodule // tb
